// >>> logic/anps_flag_if.sv
// Set, clear and state of the latching-high status flags
`timescale 1ns/1ps
interface anps_flag_if #(parameter int N = 3);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] q;
  modport owner (input set, input clr, output q);
  modport user  (output set, output clr, input q);
endinterface : anps_flag_if

// >>> logic/anps_lh_flags.sv
// Bank of latching-high flags, set wins over clear
`timescale 1ns/1ps
module anps_lh_flags #(
  parameter int N = 3
) (
  input  wire logic  clk_sys,   // System clock
  input  wire logic  resetn,    // Async reset, active low
  anps_flag_if.owner fl         // Flag set, clear and state
);
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_flag
      logic q_reg;
      logic q_next;
      // Event in the clearing cycle still sets
      assign q_next = fl.set[i] | (q_reg & ~fl.clr[i]);
      always_ff @(posedge clk_sys or negedge resetn)
      begin
        if (!resetn)
          q_reg <= 1'b0;
        else
          q_reg <= q_next;
      end
      assign fl.q[i] = q_reg;

      a_flag_holds : assert property (@(posedge clk_sys) disable iff (!resetn)
        q_reg && !fl.clr[i] |=> q_reg)
        else $error("latched flag dropped without a clear");
    end
  endgenerate
endmodule : anps_lh_flags

// >>> logic/anps_page_store.sv
// Storage of the received base page and next page code words
`timescale 1ns/1ps
module anps_page_store
  import anps_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         clk_sys,     // System clock
  input  wire logic         resetn,      // Async reset, active low
  input  wire logic         page_valid,  // New page arrived, one cycle
  input  wire logic         page_base,   // High for a base page
  input  wire logic [W-1:0] page_word,   // Received code word
  output logic      [W-1:0] base_q,      // Stored base page
  output logic      [W-1:0] next_q       // Stored next page
);
  logic [W-1:0] base_reg;
  logic [W-1:0] next_reg;
  wire          wr_base = page_valid & page_base;
  wire          wr_next = page_valid & ~page_base;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      base_reg <= PAGE_RESET[W-1:0];
      next_reg <= PAGE_RESET[W-1:0];
    end
    else
    begin
      if (wr_base)
        base_reg <= page_word;
      if (wr_next)
        next_reg <= page_word;
    end
  end

  assign base_q = base_reg;
  assign next_q = next_reg;

  a_page_stored : assert property (@(posedge clk_sys) disable iff (!resetn)
    page_valid |=> ($past(page_base) ? base_reg : next_reg) == $past(page_word))
    else $error("received page not stored in its register");
endmodule : anps_page_store

// >>> logic/anps_pkg.sv
// Constants for the partner ability and expansion status block
package anps_pkg;
  localparam int          ADDR_W          = 5;
  localparam int          DATA_W          = 16;
  // Register offsets
  localparam logic [4:0]  OFS_PARTNER     = 5'h05;
  localparam logic [4:0]  OFS_EXPANSION   = 5'h06;
  localparam logic [4:0]  OFS_NEXT_RX     = 5'h08;
  // Partner ability fields
  localparam int          PA_NEXT_PAGE    = 15;
  localparam int          PA_ACK          = 14;
  localparam int          PA_REM_FAULT    = 13;
  localparam int          PA_RSVD         = 12;
  localparam int          PA_ASYM_PAUSE   = 11;
  localparam int          PA_PAUSE        = 10;
  localparam int          PA_TECH_HI      = 9;
  localparam int          PA_TECH_LO      = 5;
  localparam int          PA_SEL_HI       = 4;
  localparam int          PA_SEL_LO       = 0;
  localparam logic [4:0]  SEL_8023        = 5'h01;
  localparam logic [4:0]  SEL_8029        = 5'h02;
  // Expansion fields
  localparam int          EX_BASE_PAGE    = 5;
  localparam int          EX_PAR_FAULT    = 4;
  localparam int          EX_LP_NP_ABLE   = 3;
  localparam int          EX_NP_ABLE      = 2;
  localparam int          EX_PAGE_RX      = 1;
  localparam int          EX_LP_AN_ABLE   = 0;
  // Latching flag indices
  localparam int          NUM_FLAGS       = 3;
  localparam int          FL_PAGE_RX      = 0;
  localparam int          FL_PAR_FAULT    = 1;
  localparam int          FL_BASE_PAGE    = 2;
  // Reset values
  localparam logic [15:0] PAGE_RESET      = 16'h0000;
  localparam logic        LOCAL_NP_ABLE   = 1'b1;
endpackage : anps_pkg

// >>> logic/anps_status.sv
// Partner ability and negotiation expansion status registers
// ****************************************************************
// How it works
// - Partner bit 15 shows partner can send multiple pages.
// - Partner bit 14 shows partner acknowledged our link code word.
// - Partner bit 13 shows partner's remote fault indication.
// - Partner bits 11 and 10 show asymmetric and symmetric pause.
// - Partner bits 9 to 5 show advertised technologies, T4 first.
// - Partner bits 4 to 0 hold the selector code.
// - Expansion bit 5 latches base page received, only in alternate mode.
// - Expansion bit 4 latches parallel detection fault until read.
// - Expansion bit 3 shows partner next-page able, plain status.
// - Expansion bit 2 always reads one: local device next-page able.
// - New page sets bit 1 and stores word in base or next register.
// - Page received clears on read, and in alternate mode on idle or disable.
// - Expansion bit 0 shows partner auto-negotiation able.
// ****************************************************************
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module anps_status
  import anps_pkg::*;
(
  input  wire logic                       clk_sys,            // System clock, 40 MHz
  input  wire logic                       resetn,             // Async reset, active low
  input  wire logic [anps_pkg::ADDR_W-1:0] addr,               // Register address
  input  wire logic [anps_pkg::DATA_W-1:0] wr_data,            // Write data, ignored
  input  wire logic                       wr_en,              // Write strobe, ignored
  input  wire logic                       rd_en,              // Read strobe
  output logic      [anps_pkg::DATA_W-1:0] rd_data,            // Read data, cycle after strobe
  input  wire logic                       page_valid,         // New page received, one cycle
  input  wire logic                       page_base,          // Page is a base page
  input  wire logic [anps_pkg::DATA_W-1:0] page_word,          // Received code word
  input  wire logic                       base_page_event,    // Base page variable went true
  input  wire logic                       par_fault_event,    // Parallel detection fault
  input  wire logic                       partner_an_able,    // Partner is auto-neg able
  input  wire logic                       mr_page_rx,         // Page receive variable
  input  wire logic                       transmit_disable,   // Transmit disable variable
  input  wire logic                       alt_next_page_mode, // Alternate next page mode
  output logic      [anps_pkg::DATA_W-1:0] next_page_rx        // Stored next page word
);
  import anps_pkg::*;

  // ****************************************************************
  // Page storage and latching flags
  // ****************************************************************
  logic [DATA_W-1:0] base_q;
  logic [DATA_W-1:0] next_q;
  logic [DATA_W-1:0] rd_data_reg;
  logic [DATA_W-1:0] rd_data_next;
  logic [DATA_W-1:0] np_out_reg;
  logic              an_able_reg;

  anps_flag_if #(.N(NUM_FLAGS)) fl ();

  anps_page_store #(.W(DATA_W)) u_store (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .page_valid (page_valid),
    .page_base  (page_base),
    .page_word  (page_word),
    .base_q     (base_q),
    .next_q     (next_q)
  );

  anps_lh_flags #(.N(NUM_FLAGS)) u_flags (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .fl      (fl)
  );

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire rd_partner = rd_en && (addr == OFS_PARTNER);
  wire rd_expan   = rd_en && (addr == OFS_EXPANSION);
  wire rd_next    = rd_en && (addr == OFS_NEXT_RX);
  // Writes land nowhere: every register here is read-only
  wire wr_unused  = wr_en & (|wr_data);
  // Alternate mode drops page received while the page variable is low or transmit is disabled
  wire alt_drop   = alt_next_page_mode && (!mr_page_rx || transmit_disable);

  // ****************************************************************
  // Flag events
  // ****************************************************************
  assign fl.set[FL_PAGE_RX]   = page_valid;
  assign fl.set[FL_PAR_FAULT] = par_fault_event;
  // Base page flag only tracks the state diagram in alternate mode
  assign fl.set[FL_BASE_PAGE] = base_page_event & alt_next_page_mode;
  assign fl.clr[FL_PAGE_RX]   = rd_expan | alt_drop;
  assign fl.clr[FL_PAR_FAULT] = rd_expan;
  assign fl.clr[FL_BASE_PAGE] = rd_expan;

  // ****************************************************************
  // Read data assembly
  // ****************************************************************
  wire [DATA_W-1:0] partner_word;
  wire [DATA_W-1:0] expan_word;

  assign partner_word[PA_NEXT_PAGE]            = base_q[PA_NEXT_PAGE];
  assign partner_word[PA_ACK]                  = base_q[PA_ACK];
  assign partner_word[PA_REM_FAULT]            = base_q[PA_REM_FAULT];
  assign partner_word[PA_RSVD]                 = 1'b0;
  assign partner_word[PA_ASYM_PAUSE]           = base_q[PA_ASYM_PAUSE];
  assign partner_word[PA_PAUSE]                = base_q[PA_PAUSE];
  assign partner_word[PA_TECH_HI:PA_TECH_LO]   = base_q[PA_TECH_HI:PA_TECH_LO];
  // Selector passes through as received; reserved codes are not filtered
  assign partner_word[PA_SEL_HI:PA_SEL_LO]     = base_q[PA_SEL_HI:PA_SEL_LO];

  assign expan_word[DATA_W-1:EX_BASE_PAGE+1]   = '0;
  assign expan_word[EX_BASE_PAGE]              = fl.q[FL_BASE_PAGE];
  assign expan_word[EX_PAR_FAULT]              = fl.q[FL_PAR_FAULT];
  assign expan_word[EX_LP_NP_ABLE]             = base_q[PA_NEXT_PAGE];
  assign expan_word[EX_NP_ABLE]                = LOCAL_NP_ABLE;
  assign expan_word[EX_PAGE_RX]                = fl.q[FL_PAGE_RX];
  assign expan_word[EX_LP_AN_ABLE]             = an_able_reg;

  // Unmapped addresses and idle cycles read zero
  assign rd_data_next = rd_partner ? partner_word :
                        rd_expan   ? expan_word   :
                        rd_next    ? next_q       : '0;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_data_reg <= '0;
      np_out_reg  <= PAGE_RESET;
      an_able_reg <= 1'b0;
    end
    else
    begin
      rd_data_reg <= rd_data_next;
      np_out_reg  <= next_q;
      an_able_reg <= partner_an_able;
    end
  end

  assign rd_data      = rd_data_reg;
  assign next_page_rx = np_out_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_np_bit_read : assert property (rd_partner |=> rd_data[15] == $past(base_q[15]))
    else $error("partner next page bit wrong");
  a_ack_bit_read : assert property (page_valid && page_base ##1 rd_partner |=> rd_data[14] == $past(page_word[14], 2))
    else $error("partner acknowledge bit wrong");
  a_fault_bit_read : assert property (rd_partner |=> rd_data[13] == $past(base_q[13]))
    else $error("partner remote fault bit wrong");
  a_pause_bits_read : assert property (rd_partner |=> rd_data[11:10] == $past(base_q[11:10]))
    else $error("partner pause bits wrong");
  a_tech_bits_read : assert property (rd_partner |=> rd_data[9:5] == $past(base_q[9:5]))
    else $error("partner technology bits wrong");
  a_selector_read : assert property (rd_partner |=> rd_data[4:0] == $past(base_q[4:0]) && !rd_data[12])
    else $error("partner selector or reserved bit wrong");
  a_base_flag_set : assert property (base_page_event && alt_next_page_mode |=> fl.q[FL_BASE_PAGE])
    else $error("base page flag not set");
  a_base_flag_mode : assert property (!fl.q[FL_BASE_PAGE] && !alt_next_page_mode |=> !fl.q[FL_BASE_PAGE])
    else $error("base page flag set outside alternate mode");
  a_fault_latch : assert property (par_fault_event ##1 !rd_expan[*2] |=> fl.q[FL_PAR_FAULT])
    else $error("parallel fault flag not latched");
  a_lp_np_read : assert property (rd_expan |=> rd_data[3] == $past(base_q[15]))
    else $error("partner next page able wrong");
  a_local_np_one : assert property (rd_expan |=> rd_data[2] && rd_data[15:6] == '0)
    else $error("local next page able not one");
  a_page_rx_set : assert property (page_valid |=> fl.q[FL_PAGE_RX])
    else $error("page received not set");
  a_page_rx_clear : assert property ((rd_expan || alt_drop) && !page_valid |=> !fl.q[FL_PAGE_RX])
    else $error("page received not cleared");
  a_an_able_read : assert property (rd_expan |=> rd_data[0] == $past(an_able_reg))
    else $error("partner auto-neg able wrong");
  a_write_no_effect : assert property (wr_en && !page_valid |=> $stable(base_q) && $stable(next_q))
    else $error("write changed a read-only register");
  a_read_then_clear : assert property (fl.q[FL_PAR_FAULT] && rd_expan && !par_fault_event
    |=> rd_data[4] && !fl.q[FL_PAR_FAULT])
    else $error("latched read did not return one then clear");
endmodule : anps_status

// >>> tb/anps_link_partner.sv
// Behavioural remote link partner that delivers received pages
`timescale 1ns/1ps
module anps_link_partner (
  input  wire logic        clk_sys,    // System clock
  input  wire logic        send,       // Request to deliver one page
  input  wire logic        is_base,    // Page kind to deliver
  input  wire logic [15:0] word,       // Code word to deliver
  output logic             page_valid, // One-cycle page strobe
  output logic             page_base,  // Base page flag
  output logic      [15:0] page_word   // Received code word
);
  initial
  begin
    page_valid = 1'b0;
    page_base  = 1'b0;
    page_word  = 16'h0000;
  end
  // Idle lines toggle so a design reading them off-strobe is caught
  always @(posedge clk_sys)
  begin
    page_valid <= send;
    page_base  <= send ? is_base : ~page_base;
    page_word  <= send ? word : ~page_word;
  end
endmodule : anps_link_partner

// >>> tb/anps_status_bench.sv
// Self-checking bench for the partner ability status block
`timescale 1ns/1ps
module anps_status_bench;
  import anps_pkg::*;
  logic        clk_sys, resetn, wr_en, rd_en, send, is_base;
  logic        pv, pb, bpe, pfe, an, mpr, txd, alt;
  logic [4:0]  addr;
  logic [15:0] wr_data, word, rd_data, nxt, pw, bw, w, d;
  logic [15:0] corner [4] = '{16'h8001, 16'h4002, 16'h2c00, 16'h73ff};
  int          fail_count, comparisons;
  // ****************************************************************
  // Clock, design and partner
  // ****************************************************************
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  anps_status i_dut (.clk_sys(clk_sys), .resetn(resetn), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .page_valid(pv), .page_base(pb),
    .page_word(pw), .base_page_event(bpe), .par_fault_event(pfe), .partner_an_able(an),
    .mr_page_rx(mpr), .transmit_disable(txd), .alt_next_page_mode(alt), .next_page_rx(nxt));
  anps_link_partner i_lp (.clk_sys(clk_sys), .send(send), .is_base(is_base), .word(word),
    .page_valid(pv), .page_base(pb), .page_word(pw));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  function automatic logic [15:0] ex(input logic np, bp, pf, pr, a);
    return {10'h000, bp, pf, np, LOCAL_NP_ABLE, pr, a};
  endfunction : ex
  // Reserved bit 12 of the partner word always reads zero
  function automatic logic [15:0] pa(input logic [15:0] v);
    return {v[15:13], 1'b0, v[11:0]};
  endfunction : pa
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task rd(input logic [4:0] a);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : rd
  task wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    addr    <= a;
    wr_data <= v;
    wr_en   <= 1'b1;
    @(posedge clk_sys);
    wr_en   <= 1'b0;
  endtask : wr
  task pg(input logic b, input logic [15:0] v);
    @(posedge clk_sys);
    send    <= 1'b1;
    is_base <= b;
    word    <= v;
    @(posedge clk_sys);
    send    <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : pg
  task ev(input logic b, input logic f);
    @(posedge clk_sys);
    bpe <= b;
    pfe <= f;
    @(posedge clk_sys);
    bpe <= 1'b0;
    pfe <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : ev
  task finish_test;
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial
  begin
    #(25 * 20000);
    fail_count++;
    finish_test();
  end
  initial
  begin
    void'($urandom(87179));
    {resetn, wr_en, rd_en, send, is_base, bpe, pfe, an, txd, alt} = '0;
    {addr, wr_data, word} = '0;
    mpr = 1'b1;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(OFS_PARTNER);   chk(d, 16'h0000);
    rd(OFS_EXPANSION); chk(d, ex(0, 0, 0, 0, 0));
    @(posedge clk_sys); #1 chk(rd_data, 16'h0000);
    rd(5'h1f);         chk(d, 16'h0000);
    for (int i = 0; i < 16; i++)
    begin
      w = (i < 4) ? corner[i] : 16'($urandom);
      @(posedge clk_sys);
      an <= 1'($urandom);
      pg(1'b1, w);
      bw = w;
      rd(OFS_PARTNER);   chk(d, pa(w));
      rd(OFS_EXPANSION); chk(d, ex(w[15], 0, 0, 1, an));
      rd(OFS_EXPANSION); chk(d, ex(w[15], 0, 0, 0, an));
      wr(OFS_PARTNER, 16'($urandom));
      wr(OFS_EXPANSION, 16'($urandom));
      rd(OFS_PARTNER);   chk(d, pa(w));
    end
    w = 16'($urandom);
    pg(1'b0, w);       chk(nxt, w);
    rd(OFS_PARTNER);   chk(d, pa(bw));
    rd(OFS_NEXT_RX);   chk(d, w);
    // Base page read in the cycle right after it is stored
    bw = 16'($urandom);
    @(posedge clk_sys);
    send    <= 1'b1;
    is_base <= 1'b1;
    word    <= bw;
    @(posedge clk_sys);
    send    <= 1'b0;
    rd(OFS_PARTNER);   chk(d, pa(bw));
    rd(OFS_EXPANSION); chk(d, ex(bw[15], 0, 0, 1, an));
    ev(1'b1, 1'b1);
    rd(OFS_EXPANSION); chk(d, ex(bw[15], 0, 1, 0, an));
    rd(OFS_EXPANSION); chk(d, ex(bw[15], 0, 0, 0, an));
    @(posedge clk_sys);
    alt <= 1'b1;
    ev(1'b1, 1'b0);
    rd(OFS_EXPANSION); chk(d, ex(bw[15], 1, 0, 0, an));
    rd(OFS_EXPANSION); chk(d, ex(bw[15], 0, 0, 0, an));
    pg(1'b1, bw);
    rd(OFS_EXPANSION); chk(d, ex(bw[15], 0, 0, 1, an));
    pg(1'b1, bw);
    @(posedge clk_sys);
    mpr <= 1'b0;
    repeat (3) @(posedge clk_sys);
    mpr <= 1'b1;
    rd(OFS_EXPANSION); chk(d, ex(bw[15], 0, 0, 0, an));
    pg(1'b1, bw);
    @(posedge clk_sys);
    txd <= 1'b1;
    repeat (3) @(posedge clk_sys);
    txd <= 1'b0;
    rd(OFS_EXPANSION); chk(d, ex(bw[15], 0, 0, 0, an));
    finish_test();
  end
endmodule : anps_status_bench
